// ===== shared/earom_regs.svh
// Timing, width and encoding constants for the memory operation sequencer
`ifndef EAROM_SEQ_REGS_SVH
`define EAROM_SEQ_REGS_SVH

// ==========================================
// Clock and interval figures
`define EAROM_CLK_MHZ 125
`define EAROM_WRITE_TIME_US 1000
`define EAROM_ERASE_TIME_US 12000
`define EAROM_BLOCK_ERASE_TIME_US 1000
`define EAROM_SETUP_CYCLES 2
`define EAROM_STROBE_CYCLES 8
`define EAROM_STROBE_CNT_W 8

// ==========================================
// Widths
`define EAROM_DATA_W 8
`define EAROM_PART_ADDR_W 10
`define EAROM_OP_W 3

// ==========================================
// Operation codes on op_i
`define EAROM_OP_READ 3'h0
`define EAROM_OP_BLOCK_ERASE 3'h1
`define EAROM_OP_WORD_ERASE 3'h2
`define EAROM_OP_WRITE 3'h3
`define EAROM_OP_REPROGRAM 3'h4

// ==========================================
// Mode line encodings {mode_select_high, mode_select_low}
`define EAROM_MODE_READ 2'h0
`define EAROM_MODE_WRITE 2'h1
`define EAROM_MODE_BLOCK_ERASE 2'h2
`define EAROM_MODE_WORD_ERASE 2'h3

`endif

// ===== shared/earom_pkg.sv
// Types shared by the memory operation sequencer
`default_nettype none

package earom_pkg;

  // ==========================================
  // Sequencer states
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SETUP,
    ST_ARM,
    ST_STROBE,
    ST_TIMING,
    ST_DUMMY_SETUP,
    ST_DUMMY_STROBE,
    ST_FINISH
  } state_t;

endpackage : earom_pkg

`default_nettype wire

// ===== logic/interval_timer.sv
// Down-counter that flags the end of a loaded interval
`timescale 1ns/1ns
`default_nettype none

module interval_timer #(
  parameter int WIDTH = 21
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // Control
  input wire logic start_i,
  input wire logic [WIDTH-1:0] count_i,
  // Status
  output logic expired_o
);

  // The one-count compare needs at least one padding bit
  if (WIDTH < 2) begin : g_bad_width
    $error("WIDTH must be at least 2");
  end

  logic [WIDTH-1:0] cnt;
  logic [WIDTH-1:0] next_cnt;
  logic running;
  logic next_running;
  logic next_expired;

  always_comb begin
    next_cnt = cnt;
    next_running = running;
    next_expired = 1'b0;
    if (start_i) begin
      next_cnt = count_i;
      next_running = 1'b1;
    end else if (running) begin
      if (cnt <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
        next_running = 1'b0;
        next_expired = 1'b1;
      end else begin
        next_cnt = cnt - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      cnt <= '0;
      running <= 1'b0;
      expired_o <= 1'b0;
    end else begin
      cnt <= next_cnt;
      running <= next_running;
      expired_o <= next_expired;
    end
  end

endmodule : interval_timer

`default_nettype wire

// ===== logic/earom_operation_sequencer.sv
// Host-side sequencer that drives one or two pairs of 4-bit memory parts as one byte-wide store
`timescale 1ns/1ns
`default_nettype none
`include "earom_regs.svh"

// What this block does
// - Both parts share address, mode; byte-wide data
// - Ten shared address lines, three control lines
// - Read, block erase, word erase, write, reprogram
// - Write strobe follows the chip-select strobe
// - Read: read mode, strobe low, capture byte
// - Idle and address setup use read mode
// - Reprogram erase: word erase, 12 ms, dummy read
// - Write: drive data, strobe, 1 ms, dummy read
// - Flag tracks erase half, cleared before finishing
// - Block erase sets all ones, 1 ms
// - Write only words already erased (plain write does not erase first; reprogram does)
// - Address and data held unchanged after reprogram
// - Dummy read: read mode, strobe low then high
// - Extra address bit gates each pair's strobe
// - Never skip or delay dummy read
module earom_operation_sequencer #(
  parameter int PAIRS = 1,
  parameter int CLK_MHZ = `EAROM_CLK_MHZ,
  parameter int WRITE_CYCLES = `EAROM_WRITE_TIME_US * `EAROM_CLK_MHZ,
  parameter int ERASE_CYCLES = `EAROM_ERASE_TIME_US * `EAROM_CLK_MHZ,
  parameter int BLOCK_ERASE_CYCLES = `EAROM_BLOCK_ERASE_TIME_US * `EAROM_CLK_MHZ,
  parameter int SETUP_CYCLES = `EAROM_SETUP_CYCLES,
  parameter int STROBE_CYCLES = `EAROM_STROBE_CYCLES
) (
  // Clock and reset
  input wire logic clock_i,
  input wire logic sys_rst_i,
  // User request
  input wire logic start_i,
  input wire logic [`EAROM_OP_W-1:0] op_i,
  input wire logic [`EAROM_PART_ADDR_W+PAIRS-2:0] addr_i,
  input wire logic [`EAROM_DATA_W-1:0] data_i,
  // User answer
  output logic busy_o,
  output logic done_o,
  output logic [`EAROM_DATA_W-1:0] rdata_o,
  // Memory pins
  output logic [`EAROM_PART_ADDR_W-1:0] mem_addr_o,
  output logic mode_select_low_o,
  output logic mode_select_high_o,
  output logic [PAIRS-1:0] strobe_n_o,
  output logic [PAIRS-1:0] write_strobe_n_o,
  output logic [`EAROM_DATA_W-1:0] mem_data_o,
  output logic mem_data_oe_o,
  input wire logic [`EAROM_DATA_W-1:0] mem_data_i
);

  localparam int ADDR_W = `EAROM_PART_ADDR_W + PAIRS - 1;
  localparam int TIMER_W = $clog2(ERASE_CYCLES + 1);
  localparam int CNT_W = `EAROM_STROBE_CNT_W;

  // ==========================================
  // Elaboration checks
  if (PAIRS < 1 || PAIRS > 2) begin : g_bad_pairs
    $error("PAIRS must be 1 or 2");
  end
  if (WRITE_CYCLES < 1 || BLOCK_ERASE_CYCLES < 1 || ERASE_CYCLES < WRITE_CYCLES
      || ERASE_CYCLES < BLOCK_ERASE_CYCLES) begin : g_bad_times
    $error("Interval counts must be positive and erase the longest");
  end
  if (SETUP_CYCLES < 1 || STROBE_CYCLES < 4 || SETUP_CYCLES >= (1 << CNT_W)
      || STROBE_CYCLES >= (1 << CNT_W)) begin : g_bad_pulse
    $error("Setup or strobe cycle count out of range");
  end

  // ==========================================
  // Functions
  function automatic logic [1:0] op_mode(input logic [`EAROM_OP_W-1:0] op);
    case (op)
      `EAROM_OP_BLOCK_ERASE: op_mode = `EAROM_MODE_BLOCK_ERASE;
      `EAROM_OP_WORD_ERASE: op_mode = `EAROM_MODE_WORD_ERASE;
      `EAROM_OP_REPROGRAM: op_mode = `EAROM_MODE_WORD_ERASE;
      `EAROM_OP_WRITE: op_mode = `EAROM_MODE_WRITE;
      default: op_mode = `EAROM_MODE_READ;
    endcase
  endfunction : op_mode

  // Only the pair chosen by the top address bit sees the strobe
  function automatic logic [PAIRS-1:0] strobe_vec(input logic active, input logic [ADDR_W-1:0] a);
    logic [PAIRS-1:0] v;
    v = '1;
    for (int p = 0; p < PAIRS; p++) begin
      if (active && (PAIRS == 1 || int'(a[ADDR_W-1]) == p)) begin
        v[p] = 1'b0;
      end
    end
    strobe_vec = v;
  endfunction : strobe_vec

  // ==========================================
  // Data pin synchroniser: change counts when stages two and three agree
  logic [`EAROM_DATA_W-1:0] sync1;
  logic [`EAROM_DATA_W-1:0] sync2;
  logic [`EAROM_DATA_W-1:0] sync3;
  logic [`EAROM_DATA_W-1:0] stable_data;

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      sync1 <= '0;
      sync2 <= '0;
      sync3 <= '0;
      stable_data <= '0;
    end else begin
      sync1 <= mem_data_i;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3) begin
        stable_data <= sync3;
      end
    end
  end

  // ==========================================
  // Sequencer
  earom_pkg::state_t state;
  earom_pkg::state_t next_state;
  logic [`EAROM_OP_W-1:0] cur_op;
  logic [`EAROM_OP_W-1:0] next_cur_op;
  logic [ADDR_W-1:0] addr_q;
  logic [ADDR_W-1:0] next_addr_q;
  logic [`EAROM_DATA_W-1:0] data_q;
  logic [`EAROM_DATA_W-1:0] next_data_q;
  logic [`EAROM_DATA_W-1:0] next_rdata;
  logic reprog_flag;
  logic next_reprog_flag;
  logic [1:0] mode_lines;
  logic [1:0] next_mode_lines;
  logic [PAIRS-1:0] strobe_n;
  logic [PAIRS-1:0] next_strobe_n;
  logic data_oe;
  logic next_data_oe;
  logic next_done;
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic timer_start;
  logic [TIMER_W-1:0] timer_count;
  logic timer_expired;

  interval_timer #(
    .WIDTH(TIMER_W)
  ) u_timer (
    .clock_i(clock_i),
    .sys_rst_i(sys_rst_i),
    .start_i(timer_start),
    .count_i(timer_count),
    .expired_o(timer_expired)
  );

  always_comb begin
    next_state = state;
    next_cur_op = cur_op;
    next_addr_q = addr_q;
    next_data_q = data_q;
    next_rdata = rdata_o;
    next_reprog_flag = reprog_flag;
    next_mode_lines = mode_lines;
    next_strobe_n = strobe_n;
    next_data_oe = data_oe;
    next_done = 1'b0;
    next_cnt = (cnt == '0) ? cnt : cnt - 1'b1;
    timer_start = 1'b0;
    timer_count = TIMER_W'(WRITE_CYCLES);
    case (cur_op)
      `EAROM_OP_BLOCK_ERASE: timer_count = TIMER_W'(BLOCK_ERASE_CYCLES);
      `EAROM_OP_WORD_ERASE: timer_count = TIMER_W'(ERASE_CYCLES);
      `EAROM_OP_REPROGRAM: timer_count = TIMER_W'(ERASE_CYCLES);
      default: timer_count = TIMER_W'(WRITE_CYCLES);
    endcase
    case (state)
      earom_pkg::ST_IDLE: begin
        next_mode_lines = `EAROM_MODE_READ;
        next_strobe_n = '1;
        next_data_oe = 1'b0;
        if (start_i) begin
          // Spare codes run as plain reads so they can never start a timed cycle
          next_cur_op = (op_i > `EAROM_OP_REPROGRAM) ? `EAROM_OP_READ : op_i;
          next_addr_q = addr_i;
          next_data_q = data_i;
          next_reprog_flag = (op_i == `EAROM_OP_REPROGRAM);
          next_cnt = CNT_W'(SETUP_CYCLES - 1);
          next_state = earom_pkg::ST_SETUP;
        end
      end
      earom_pkg::ST_SETUP: begin
        if (cnt == '0) begin
          // Mode lines settle a full setup time before the strobe falls
          next_mode_lines = op_mode(cur_op);
          next_data_oe = (cur_op == `EAROM_OP_WRITE);
          next_cnt = CNT_W'(SETUP_CYCLES - 1);
          next_state = earom_pkg::ST_ARM;
        end
      end
      earom_pkg::ST_ARM: begin
        if (cnt == '0) begin
          next_strobe_n = strobe_vec(1'b1, addr_q);
          next_cnt = CNT_W'(STROBE_CYCLES - 1);
          next_state = earom_pkg::ST_STROBE;
        end
      end
      earom_pkg::ST_STROBE: begin
        if (cnt == '0) begin
          next_strobe_n = '1;
          if (cur_op == `EAROM_OP_READ) begin
            next_rdata = stable_data;
            next_state = earom_pkg::ST_FINISH;
          end else begin
            timer_start = 1'b1;
            next_state = earom_pkg::ST_TIMING;
          end
        end
      end
      earom_pkg::ST_TIMING: begin
        if (timer_expired) begin
          next_mode_lines = `EAROM_MODE_READ;
          next_data_oe = 1'b0;
          next_cnt = CNT_W'(SETUP_CYCLES - 1);
          next_state = earom_pkg::ST_DUMMY_SETUP;
        end
      end
      earom_pkg::ST_DUMMY_SETUP: begin
        if (cnt == '0) begin
          next_strobe_n = strobe_vec(1'b1, addr_q);
          next_cnt = CNT_W'(STROBE_CYCLES - 1);
          next_state = earom_pkg::ST_DUMMY_STROBE;
        end
      end
      earom_pkg::ST_DUMMY_STROBE: begin
        if (cnt == '0) begin
          next_strobe_n = '1;
          if (reprog_flag) begin
            // Erase half done: the just-cleared word is now written
            next_reprog_flag = 1'b0;
            next_cur_op = `EAROM_OP_WRITE;
            next_cnt = CNT_W'(SETUP_CYCLES - 1);
            next_state = earom_pkg::ST_SETUP;
          end else begin
            next_state = earom_pkg::ST_FINISH;
          end
        end
      end
      earom_pkg::ST_FINISH: begin
        next_done = 1'b1;
        next_state = earom_pkg::ST_IDLE;
      end
      default: begin
        next_state = earom_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (sys_rst_i) begin
      state <= earom_pkg::ST_IDLE;
      cur_op <= `EAROM_OP_READ;
      addr_q <= '0;
      data_q <= '0;
      rdata_o <= '0;
      reprog_flag <= 1'b0;
      mode_lines <= `EAROM_MODE_READ;
      strobe_n <= '1;
      data_oe <= 1'b0;
      done_o <= 1'b0;
      cnt <= '0;
    end else begin
      state <= next_state;
      cur_op <= next_cur_op;
      addr_q <= next_addr_q;
      data_q <= next_data_q;
      rdata_o <= next_rdata;
      reprog_flag <= next_reprog_flag;
      mode_lines <= next_mode_lines;
      strobe_n <= next_strobe_n;
      data_oe <= next_data_oe;
      done_o <= next_done;
      cnt <= next_cnt;
    end
  end

  // ==========================================
  // Pin drive
  assign busy_o = (state != earom_pkg::ST_IDLE);
  assign mem_addr_o = addr_q[`EAROM_PART_ADDR_W-1:0];
  assign mode_select_low_o = mode_lines[0];
  assign mode_select_high_o = mode_lines[1];
  assign strobe_n_o = strobe_n;
  assign write_strobe_n_o = strobe_n;
  assign mem_data_o = data_q;
  assign mem_data_oe_o = data_oe;

  // ==========================================
  // Assertions
  logic [TIMER_W+1:0] pend_cnt;
  always_ff @(posedge clock_i) begin
    if (sys_rst_i || state == earom_pkg::ST_IDLE || state == earom_pkg::ST_SETUP) begin
      pend_cnt <= '0;
    end else if (state == earom_pkg::ST_TIMING || state == earom_pkg::ST_DUMMY_SETUP) begin
      pend_cnt <= pend_cnt + 1'b1;
    end
  end

  a_idle_read_mode: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    $past(state) == earom_pkg::ST_IDLE && !$past(start_i) |-> mode_lines == `EAROM_MODE_READ && (&strobe_n_o))
    else $error("Idle without read mode or with strobe low");
  a_dummy_in_time: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    pend_cnt <= (TIMER_W+2)'(ERASE_CYCLES + 2 * SETUP_CYCLES + 4))
    else $error("Dummy read strobe came too late");
  a_dummy_read_mode: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    state == earom_pkg::ST_DUMMY_STROBE |-> mode_lines == `EAROM_MODE_READ && !mem_data_oe_o)
    else $error("Dummy read not in read mode");
  a_one_pair_strobed: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    $countones(~strobe_n_o) <= 1)
    else $error("More than one pair strobed");
  a_pins_steady_low: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !(&strobe_n_o) && !$past(&strobe_n_o) |-> $stable(mem_addr_o) && $stable(mode_lines) && $stable(mem_data_oe_o))
    else $error("Pins moved while strobe low");
  a_flag_clear_done: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    done_o |-> !reprog_flag)
    else $error("Reprogram flag still set at finish");
  a_busy_until_done: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    $fell(busy_o) |-> done_o)
    else $error("Busy dropped before done");
  a_write_drives_data: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    !(&strobe_n_o) |-> mem_data_oe_o == (mode_lines == `EAROM_MODE_WRITE))
    else $error("Data drive does not match mode under strobe");
  a_target_kept: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    busy_o |=> $stable(addr_q) && $stable(data_q))
    else $error("Target address or data changed during operation");
  a_strobe_bounded: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    $fell(&strobe_n_o) |-> ##[1:250] (&strobe_n_o))
    else $error("Strobe held low too long");
  a_read_capture: assert property (@(posedge clock_i) disable iff (sys_rst_i)
    state == earom_pkg::ST_STROBE && cur_op == `EAROM_OP_READ && cnt == '0 |=> rdata_o == $past(stable_data) ##1 done_o)
    else $error("Read byte not captured at strobe end");

  c_read_done: cover property (@(posedge clock_i) disable iff (sys_rst_i)
    done_o && cur_op == `EAROM_OP_READ);
  c_reprogram_write_half: cover property (@(posedge clock_i) disable iff (sys_rst_i)
    $fell(reprog_flag) ##[1:300] state == earom_pkg::ST_ARM);
  c_block_erase_done: cover property (@(posedge clock_i) disable iff (sys_rst_i)
    done_o && cur_op == `EAROM_OP_BLOCK_ERASE);
  c_upper_pair: cover property (@(posedge clock_i) disable iff (sys_rst_i)
    !strobe_n_o[PAIRS-1] && PAIRS == 2);

endmodule : earom_operation_sequencer

`default_nettype wire

// ===== testbench/mem_pair_model.sv
// Behavioural model of two 4-bit memory parts working as one byte-wide store
`timescale 1ns/1ns
`default_nettype none
`include "earom_regs.svh"

module mem_pair_model #(
  parameter int MAX_LOW = 16,
  parameter int MAX_GAP = 200,
  parameter int SLOW_DELAY = 2
) (
  // Clock
  input wire logic clock_i,
  // Memory pins
  input wire logic [9:0] addr_i,
  input wire logic mode_select_low_i,
  input wire logic mode_select_high_i,
  input wire logic strobe_n_i,
  input wire logic write_strobe_n_i,
  input wire logic [7:0] data_i,
  input wire logic host_oe_i,
  output logic [7:0] data_o,
  // Bench control and observation
  input wire logic slow_i,
  output int op_count_o,
  output logic [1:0] last_mode_o,
  output int last_gap_o,
  output int fault_count_o
);
  // ==========================================
  // Cell array and latched operation
  logic [7:0] cells [0:1023];
  logic [1:0] mode;
  logic [1:0] held_mode;
  logic [1:0] low_mode;
  logic [9:0] held_addr;
  logic [9:0] low_addr;
  logic [9:0] rd_addr;
  logic [7:0] held_data;
  logic pending = 1'b0;
  logic prev_n = 1'b1;
  logic reading = 1'b0;
  int low_len = 0;
  int gap = 0;
  int wait_cnt = 0;

  assign mode = {mode_select_high_i, mode_select_low_i};

  initial begin
    for (int i = 0; i < 1024; i++) cells[i] = 8'h00;
    data_o = 8'h5a;
    op_count_o = 0;
    last_mode_o = 2'h0;
    last_gap_o = 0;
    fault_count_o = 0;
  end

  // ==========================================
  // Alteration takes effect when the dummy read ends it
  task automatic apply_op;
    case (held_mode)
      `EAROM_MODE_BLOCK_ERASE: for (int i = 0; i < 1024; i++) cells[i] = 8'hff;
      `EAROM_MODE_WORD_ERASE: cells[held_addr] = 8'hff;
      default: begin
        if (cells[held_addr] !== 8'hff) fault_count_o++;
        cells[held_addr] = held_data;
      end
    endcase
  endtask : apply_op

  // ==========================================
  // Pin behaviour
  always @(posedge clock_i) begin
    if (write_strobe_n_i !== strobe_n_i) fault_count_o++;
    gap++;
    wait_cnt++;
    if (prev_n === 1'b1 && strobe_n_i === 1'b0) begin
      low_len = 0;
      wait_cnt = 0;
      low_mode = mode;
      low_addr = addr_i;
      if (mode !== `EAROM_MODE_READ) begin
        held_mode = mode;
        held_addr = addr_i;
        held_data = data_i;
        pending = 1'b1;
        op_count_o++;
        last_mode_o = mode;
      end else begin
        if (pending) begin
          apply_op();
          last_gap_o = gap;
          pending = 1'b0;
        end
        reading = 1'b1;
        rd_addr = addr_i;
      end
    end else if (strobe_n_i === 1'b0) begin
      low_len++;
      if (low_len > MAX_LOW || mode !== low_mode || addr_i !== low_addr) fault_count_o++;
    end
    if (prev_n === 1'b0 && strobe_n_i === 1'b1) begin
      reading = 1'b0;
      gap = 0;
    end
    if (pending && gap == MAX_GAP) fault_count_o++;
    if (host_oe_i && reading) fault_count_o++;
    // Released pins toggle so a stale byte can never pass for a read
    if (reading && wait_cnt >= (slow_i ? SLOW_DELAY : 0)) data_o <= cells[rd_addr];
    else data_o <= ~data_o;
    prev_n = strobe_n_i;
  end
endmodule : mem_pair_model
`default_nettype wire

// ===== testbench/tb.sv
// Self-checking bench for the memory operation sequencer
`timescale 1ns/1ns
`default_nettype none
`include "earom_regs.svh"

module tb;
  // ==========================================
  // Signals
  localparam int WR = 20;
  localparam int BE = 20;
  localparam int ER = 40;
  logic clock_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic start_i = 1'b0;
  logic [2:0] op_i = 3'h0;
  logic [9:0] addr_i = 10'h000;
  logic [7:0] data_i = 8'h00;
  logic busy_o, done_o, mode_select_low_o, mode_select_high_o, mem_data_oe_o;
  logic [7:0] rdata_o, mem_data_o, model_data, bus;
  logic [9:0] mem_addr_o, a;
  logic [7:0] d;
  logic [0:0] strobe_n_o, write_strobe_n_o;
  logic slow = 1'b0;
  logic [1:0] last_mode;
  int op_count, last_gap, fault_count, c0;
  int bad_count = 0;
  int checks = 0;
  int seed = 97;
  int mem [0:1023];

  always #4 clock_i = ~clock_i;
  assign bus = mem_data_oe_o ? mem_data_o : model_data;

  earom_operation_sequencer #(.PAIRS(1), .WRITE_CYCLES(WR), .ERASE_CYCLES(ER), .BLOCK_ERASE_CYCLES(BE)) dut (
    .clock_i(clock_i), .sys_rst_i(sys_rst_i), .start_i(start_i), .op_i(op_i), .addr_i(addr_i),
    .data_i(data_i), .busy_o(busy_o), .done_o(done_o), .rdata_o(rdata_o), .mem_addr_o(mem_addr_o),
    .mode_select_low_o(mode_select_low_o), .mode_select_high_o(mode_select_high_o),
    .strobe_n_o(strobe_n_o), .write_strobe_n_o(write_strobe_n_o), .mem_data_o(mem_data_o),
    .mem_data_oe_o(mem_data_oe_o), .mem_data_i(bus));

  mem_pair_model model (
    .clock_i(clock_i), .addr_i(mem_addr_o), .mode_select_low_i(mode_select_low_o),
    .mode_select_high_i(mode_select_high_o), .strobe_n_i(strobe_n_o[0]),
    .write_strobe_n_i(write_strobe_n_o[0]), .data_i(bus), .host_oe_i(mem_data_oe_o), .data_o(model_data),
    .slow_i(slow), .op_count_o(op_count), .last_mode_o(last_mode), .last_gap_o(last_gap),
    .fault_count_o(fault_count));

  // ==========================================
  // Compare tasks
  task automatic check_val(input logic [15:0] got, input logic [15:0] exp, input string s);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %h expected %h", $time, s, got, exp);
    end
  endtask : check_val

  task automatic check_count(input int got, input int exp, input string s);
    checks++;
    if (got != exp) begin
      bad_count++;
      $display("unexpected at %0t: %s got %0d expected %0d", $time, s, got, exp);
    end
  endtask : check_count

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : finish_test

  // ==========================================
  // Operations; entered at a falling edge so requests run back to back
  task automatic do_op(input logic [2:0] op, input logic [9:0] ad, input logic [7:0] dt, input logic poke);
    int n;
    start_i = 1'b1;
    op_i = op;
    addr_i = ad;
    data_i = dt;
    @(negedge clock_i);
    start_i = 1'b0;
    if (poke) begin
      // A second request while busy must be dropped
      @(negedge clock_i);
      start_i = 1'b1;
      op_i = 3'h1;
      addr_i = ~ad;
      @(negedge clock_i);
      start_i = 1'b0;
    end
    n = 0;
    while (done_o !== 1'b1 && n < 500) begin
      @(negedge clock_i);
      n++;
    end
    check_count(n < 500 ? 1 : 0, 1, "done seen");
    @(negedge clock_i);
    check_val({12'h0, strobe_n_o[0], mode_select_high_o, mode_select_low_o, mem_data_oe_o}, 16'h8, "idle");
  endtask : do_op

  task automatic read_chk(input logic [9:0] ad);
    do_op(3'h0, ad, 8'h00, 1'b0);
    check_val({8'h0, rdata_o}, {8'h0, mem[ad][7:0]}, "read data");
  endtask : read_chk

  task automatic alter(input logic [2:0] op, input logic [9:0] ad, input logic [7:0] dt,
                       input int nops, input logic [1:0] md, input int ivl);
    c0 = op_count;
    do_op(op, ad, dt, 1'b0);
    check_count(op_count - c0, nops, "alterations");
    check_val({14'h0, last_mode}, {14'h0, md}, "mode");
    check_count((last_gap >= ivl && last_gap <= ivl + 12) ? 1 : 0, 1, "interval");
    check_val({6'h0, mem_addr_o}, {6'h0, ad}, "held address");
    check_val({8'h0, mem_data_o}, {8'h0, dt}, "held data");
    if (op == 3'h1) for (int i = 0; i < 1024; i++) mem[i] = 255;
    else mem[ad] = (op == 3'h2) ? 255 : int'(dt);
  endtask : alter

  // ==========================================
  // Main sequence
  initial begin
    for (int i = 0; i < 1024; i++) mem[i] = 0;
    repeat (10) @(negedge clock_i);
    sys_rst_i = 1'b0;
    check_val({busy_o, done_o, mem_data_oe_o, strobe_n_o[0], mode_select_high_o, mode_select_low_o, rdata_o},
              16'h0400, "reset lines");
    alter(3'h1, 10'h2a5, 8'h3c, 1, `EAROM_MODE_BLOCK_ERASE, BE);
    for (int i = 0; i < 4; i++) read_chk(10'(i * 341));
    for (int i = 0; i < 8; i++) begin
      a = 10'(i * 97 + ($random(seed) & 63));
      d = 8'($random(seed));
      alter(3'h3, a, d, 1, `EAROM_MODE_WRITE, WR);
      read_chk(a);
    end
    alter(3'h2, a, 8'h00, 1, `EAROM_MODE_WORD_ERASE, ER);
    read_chk(a);
    read_chk(10'(a - 97));
    alter(3'h4, a, 8'ha7, 2, `EAROM_MODE_WRITE, WR);
    read_chk(a);
    alter(3'h4, 10'(a - 97), 8'h1e, 2, `EAROM_MODE_WRITE, WR);
    read_chk(10'(a - 97));
    c0 = op_count;
    do_op(3'h0, a, 8'h00, 1'b1);
    check_count(op_count - c0, 0, "refused request");
    check_val({8'h0, rdata_o}, {8'h0, mem[a][7:0]}, "read with refusal");
    // Alternate addresses so a stale byte cannot pass for a fresh read
    for (int k = 5; k < 8; k++) begin
      logic [9:0] sa;
      sa = k[0] ? 10'(a - 97) : a;
      do_op(3'(k), sa, 8'hff, 1'b0);
      check_val({8'h0, rdata_o}, {8'h0, mem[sa][7:0]}, "spare code reads");
    end
    check_count(op_count - c0, 0, "spare codes alter nothing");
    slow = 1'b1;
    for (int i = 0; i < 3; i++) read_chk(10'(i * 97 + 3));
    start_i = 1'b1;
    op_i = 3'h1;
    @(negedge clock_i);
    start_i = 1'b0;
    repeat (25) @(negedge clock_i);
    sys_rst_i = 1'b1;
    repeat (2) @(negedge clock_i);
    sys_rst_i = 1'b0;
    check_val({12'h0, strobe_n_o[0], mode_select_high_o, mode_select_low_o, busy_o}, 16'h8, "reset abort");
    for (int i = 0; i < 1024; i++) mem[i] = 255;
    read_chk(a);
    check_count(fault_count, 0, "partner faults");
    finish_test();
  end

  initial begin
    #(20000 * 8);
    bad_count++;
    $display("unexpected at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule : tb
`default_nettype wire
